// [tic_pkg.sv]
// Constants for the trigger interface configuration register bank.
package tic_pkg;
  localparam logic [5:0]  OFS_IDENTITY  = 6'h00;
  localparam logic [5:0]  OFS_OPTICAL   = 6'h04;
  localparam logic [5:0]  OFS_INTERRUPT = 6'h08;
  localparam logic [5:0]  OFS_TRIG_DLY  = 6'h0C;
  localparam logic [5:0]  OFS_WINDOW    = 6'h10;
  localparam logic [5:0]  OFS_BLOCK     = 6'h14;
  localparam logic [5:0]  OFS_FORMAT    = 6'h18;
  localparam logic [5:0]  OFS_BUS       = 6'h1C;
  localparam logic [5:0]  OFS_TRIG_SRC  = 6'h20;
  localparam logic [5:0]  OFS_SYNC_SRC  = 6'h24;
  localparam logic [5:0]  OFS_LIMIT     = 6'h28;
  localparam logic [5:0]  AM_A24_0      = 6'h39;
  localparam logic [5:0]  AM_A24_1      = 6'h3A;
  localparam logic [5:0]  AM_A24_2      = 6'h3D;
  localparam logic [5:0]  AM_A24_3      = 6'h3E;
  localparam logic [1:0]  RUNNING_CODE  = 2'h2;
  localparam logic [7:0]  CRATE_RST     = 8'h00;
  localparam logic [8:0]  OPTICAL_RST   = 9'h1FF;
  localparam int          GATE_BIT      = 8;
  localparam logic [7:0]  VECTOR_RST    = 8'hC8;
  localparam logic [2:0]  LEVEL_RST     = 3'h5;
  localparam int          IRQ_EN_BIT    = 16;
  localparam logic [7:0]  DELAY_RST     = 8'h00;
  localparam logic [4:0]  WIDTH_RST     = 5'h07;
  localparam logic [8:0]  WIN_MAX_RST   = 9'h1FF;
  localparam logic [8:0]  WIN_MIN_RST   = 9'h000;
  localparam logic [8:0]  WIN_BASE_RST  = 9'h100;
  localparam logic [7:0]  BLOCK_RST     = 8'h01;
  localparam logic [3:0]  FORMAT_RST    = 4'h3;
  localparam logic [31:0] BUS_RST       = 32'h0000_0011;
  localparam logic [31:0] BUS_RW_MASK   = 32'hFAF3_8F9F;
  localparam int          BUS_PULSE_BIT = 24;
  localparam int          TOKEN_EN_BIT  = 1;
  localparam int          TOKEN_IN_BIT  = 9;
  localparam logic [15:0] TRIG_SRC_RST  = 16'h0000;
  localparam logic [7:0]  FORCE_CODE    = 8'hFC;
  localparam logic [7:0]  LAUNCH_CODE   = 8'h90;
  localparam logic [15:0] SYNC_SRC_RST  = 16'h0002;
  localparam int          RESET_OPT_BIT = 7;
  localparam logic [7:0]  SYNC_SET_CODE = 8'h99;
  localparam logic [7:0]  SYNC_CLR_CODE = 8'hCC;
  localparam int          HIST_DEPTH    = 1024;
  localparam int          HIST_HALF     = 512;
  localparam logic [9:0]  DLY_LONG_OFS  = 10'h040;
  typedef enum logic [0:0] {TIC_IDLE, TIC_ACK} tic_state_t;
endpackage

// [tic_trigger_interface_config_regs.sv]
// Configuration register bank of the crate trigger interface, reached by A24 D32 cycles.
//
// Operation
// - A24 D32 access, A23..A19 match slot address
// - Crate identifier read/write, reset zero
// - Read-only board type and PCB setting
// - Running mode bits and slot address parity
// - Eight optical port enables, all set
// - Bit 8 gates trigger and restart outputs
// - Per-port link synced and remote enabled flags
// - Interrupt vector, level and enable fields
// - Primary delay with two step ranges
// - Primary pulse width field plus one
// - Secondary delay and width, same encodings
// - Wide window max, min and base fields
// - Block size stored, used levels read back
// - Data format bits select event words
// - Bus setting reset value, bus error enable
// - Token passing controls and token output
// - Instant update, buffer select, threshold enable
// - Sixteen trigger source enables, monitor readback
// - Code 0xFC forces trigger origin send
// - Code 0x90 forces front output four
// - Sync enables, reset level, last codes
// - Sync history empty, half and full flags
`timescale 1ns/100ps
module tic_trigger_interface_config_regs #(
  parameter logic [7:0] BOARD_TYPE  = 8'h5A, // Arbitrary value.
  parameter logic [7:0] PCB_SETTING = 8'h01,
  parameter int         HIST_DEPTH  = tic_pkg::HIST_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [23:2] vme_addr,
  input  wire logic [5:0]  vme_am,
  input  wire logic        vme_as_n,
  input  wire logic        vme_ds_n,
  input  wire logic        vme_write_n,
  input  wire logic [31:0] vme_data_in,
  output logic      [31:0] vme_data_out,
  output logic             vme_data_oe_n,
  output logic             vme_dtack_n,
  input  wire logic [4:0]  ga_n,
  input  wire logic        ga_parity_n,
  input  wire logic        vme64x_crate,
  input  wire logic [4:0]  slot_switches,
  input  wire logic [1:0]  running_mode,
  input  wire logic [7:0]  link_synced,
  input  wire logic [7:0]  remote_trig_on,
  input  wire logic [7:0]  block_level_used,
  input  wire logic [7:0]  block_level_master,
  input  wire logic [7:0]  buffer_level_used,
  input  wire logic [7:0]  buffer_level_master,
  input  wire logic [15:0] trigger_monitor,
  input  wire logic [7:0]  sync_monitor,
  input  wire logic        sync_code_valid,
  input  wire logic [7:0]  sync_code,
  input  wire logic [1:0]  sync_code_src,
  input  wire logic        sync_hist_pop,
  input  wire logic        trigger_raw,
  input  wire logic        sync_restart_raw,
  input  wire logic [3:0]  fp_user_out,
  output logic      [7:0]  crate_id,
  output logic      [7:0]  optical_port_enable,
  output logic             trig_out,
  output logic             sync_restart_pulse,
  output logic      [7:0]  irq_vector,
  output logic      [2:0]  irq_level,
  output logic             irq_enable,
  output logic      [9:0]  trig1_delay_steps,
  output logic      [5:0]  trig1_width_steps,
  output logic      [9:0]  trig2_delay_steps,
  output logic      [5:0]  trig2_width_steps,
  output logic      [8:0]  window_max,
  output logic      [8:0]  window_min,
  output logic      [8:0]  window_base,
  output logic      [3:0]  data_format,
  output logic      [31:0] bus_setting,
  output logic             block_decrement,
  output logic             token_out,
  output logic      [15:0] trigger_enable,
  output logic             force_origin_send,
  output logic      [3:0]  fp_out,
  output logic      [15:0] sync_enable,
  output logic             reset_level,
  output logic      [5:0]  hist_data
);
  localparam int PW = $clog2(HIST_DEPTH);

  // Delay in 16 ns steps: short range value+1, long range (value+64) x 4.
  function automatic logic [9:0] delay_steps(input logic [7:0] f);
    logic [9:0] v;
    v = {3'h0, f[6:0]};
    if (f[7]) begin
      delay_steps = (v + tic_pkg::DLY_LONG_OFS) << 2;
    end else begin
      delay_steps = v + 10'h001;
    end
  endfunction

  // Pulse width in 4 ns steps.
  function automatic logic [5:0] width_steps(input logic [4:0] f);
    width_steps = {1'b0, f} + 6'h01;
  endfunction

  // All bus pins are asynchronous to mclk and pass two flip-flops first.
  localparam int SW = 22 + 6 + 3 + 32 + 5 + 1 + 1 + 5;
  logic [SW-1:0] pin_s1_r;
  logic [SW-1:0] pin_s2_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
    end else begin
      pin_s1_r <= {vme_addr, vme_am, vme_as_n, vme_ds_n, vme_write_n, vme_data_in,
                   ga_n, ga_parity_n, vme64x_crate, slot_switches};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [23:2] addr_s;
  logic [5:0]  am_s;
  logic        as_n_s;
  logic        ds_n_s;
  logic        wr_n_s;
  logic [31:0] wdata_s;
  logic [4:0]  ga_n_s;
  logic        gap_n_s;
  logic        vme64x_s;
  logic [4:0]  sw_s;
  assign {addr_s, am_s, as_n_s, ds_n_s, wr_n_s, wdata_s,
          ga_n_s, gap_n_s, vme64x_s, sw_s} = pin_s2_r;

  logic [4:0] slot_addr;
  assign slot_addr = vme64x_s ? ~ga_n_s : sw_s;

  logic [5:0] ofs;
  assign ofs = {addr_s[5:2], 2'h0};

  logic am_ok;
  assign am_ok = (am_s == tic_pkg::AM_A24_0) || (am_s == tic_pkg::AM_A24_1) ||
                 (am_s == tic_pkg::AM_A24_2) || (am_s == tic_pkg::AM_A24_3);

  logic hit;
  assign hit = am_ok && !as_n_s && (addr_s[23:19] == slot_addr) &&
               (addr_s[18:6] == 13'h0000) && (ofs < tic_pkg::OFS_LIMIT);

  // Data strobe must be seen low twice so address and data have settled.
  logic ds_d_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ds_d_r <= 1'b1;
    end else begin
      ds_d_r <= ds_n_s;
    end
  end

  tic_pkg::tic_state_t state_r;
  logic start;
  assign start = (state_r == tic_pkg::TIC_IDLE) && !ds_n_s && !ds_d_r && hit;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= tic_pkg::TIC_IDLE;
    end else begin
      case (state_r)
        tic_pkg::TIC_IDLE: begin
          if (start) begin
            state_r <= tic_pkg::TIC_ACK;
          end
        end
        tic_pkg::TIC_ACK: begin
          if (ds_n_s) begin
            state_r <= tic_pkg::TIC_IDLE;
          end
        end
        default: begin
          state_r <= tic_pkg::TIC_IDLE;
        end
      endcase
    end
  end

  // Writes are refused while running mode is reported; the cycle still ends.
  logic locked;
  assign locked = (running_mode == tic_pkg::RUNNING_CODE);
  logic wr;
  assign wr = start && !wr_n_s && !locked;
  logic rd;
  assign rd = start && wr_n_s;

  logic [8:0]  optical_r;
  logic [7:0]  block_size_r;
  logic [7:0]  trig1_delay_r;
  logic [4:0]  trig1_width_r;
  logic [7:0]  trig2_delay_r;
  logic [4:0]  trig2_width_r;
  logic [11:0] last_codes_r;
  logic        hist_empty;
  logic        hist_half;
  logic        hist_full;

  // Read mux; unlisted bits stay zero.
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    case (ofs)
      tic_pkg::OFS_IDENTITY: begin
        rdata = {BOARD_TYPE, PCB_SETTING, running_mode, ~gap_n_s,
                 slot_addr, crate_id};
      end
      tic_pkg::OFS_OPTICAL: begin
        rdata = {remote_trig_on, link_synced, 7'h00, optical_r};
      end
      tic_pkg::OFS_INTERRUPT: begin
        rdata = {15'h0000, irq_enable, 5'h00, irq_level, irq_vector};
      end
      tic_pkg::OFS_TRIG_DLY: begin
        rdata = {3'h0, trig2_width_r, trig2_delay_r, 3'h0, trig1_width_r, trig1_delay_r};
      end
      tic_pkg::OFS_WINDOW: begin
        rdata = {window_base, window_min, window_max, 5'h00};
      end
      tic_pkg::OFS_BLOCK: begin
        rdata = {block_level_master, block_level_used, 8'h00, block_size_r};
      end
      tic_pkg::OFS_FORMAT: begin
        rdata = {buffer_level_master, buffer_level_used, 12'h000, data_format};
      end
      tic_pkg::OFS_BUS: begin
        rdata = bus_setting;
      end
      tic_pkg::OFS_TRIG_SRC: begin
        rdata = {trigger_monitor, trigger_enable};
      end
      tic_pkg::OFS_SYNC_SRC: begin
        rdata = {sync_monitor, 1'b0, hist_full, hist_half, hist_empty,
                 last_codes_r, sync_enable[7:0]};
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vme_data_out  <= 32'h0000_0000;
      vme_data_oe_n <= 1'b1;
      vme_dtack_n   <= 1'b1;
    end else if (start) begin
      vme_data_out  <= rd ? rdata : 32'h0000_0000;
      vme_data_oe_n <= !rd;
      vme_dtack_n   <= 1'b0;
    end else if (ds_n_s) begin
      vme_data_oe_n <= 1'b1;
      vme_dtack_n   <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crate_id  <= tic_pkg::CRATE_RST;
      optical_r <= tic_pkg::OPTICAL_RST;
    end else if (wr && ofs == tic_pkg::OFS_IDENTITY) begin
      crate_id <= wdata_s[7:0];
    end else if (wr && ofs == tic_pkg::OFS_OPTICAL) begin
      optical_r <= wdata_s[8:0];
    end
  end

  // Gated outputs are registered and go low one cycle after the gate bit clears.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      optical_port_enable <= 8'hFF;
      trig_out            <= 1'b0;
      sync_restart_pulse  <= 1'b0;
    end else begin
      optical_port_enable <= optical_r[7:0];
      trig_out            <= trigger_raw && optical_r[tic_pkg::GATE_BIT];
      sync_restart_pulse  <= sync_restart_raw && optical_r[tic_pkg::GATE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_vector <= tic_pkg::VECTOR_RST;
      irq_level  <= tic_pkg::LEVEL_RST;
      irq_enable <= 1'b0;
    end else if (wr && ofs == tic_pkg::OFS_INTERRUPT) begin
      irq_vector <= wdata_s[7:0];
      irq_level  <= wdata_s[10:8];
      irq_enable <= wdata_s[tic_pkg::IRQ_EN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig1_delay_r <= tic_pkg::DELAY_RST;
      trig1_width_r <= tic_pkg::WIDTH_RST;
      trig2_delay_r <= tic_pkg::DELAY_RST;
      trig2_width_r <= tic_pkg::WIDTH_RST;
    end else if (wr && ofs == tic_pkg::OFS_TRIG_DLY) begin
      trig1_delay_r <= wdata_s[7:0];
      trig1_width_r <= wdata_s[12:8];
      trig2_delay_r <= wdata_s[23:16];
      trig2_width_r <= wdata_s[28:24];
    end
  end

  // Decoded counts are registered so the delay logic sees flop outputs.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig1_delay_steps <= 10'h001;
      trig1_width_steps <= 6'h08;
      trig2_delay_steps <= 10'h001;
      trig2_width_steps <= 6'h08;
    end else begin
      trig1_delay_steps <= delay_steps(trig1_delay_r);
      trig1_width_steps <= width_steps(trig1_width_r);
      trig2_delay_steps <= delay_steps(trig2_delay_r);
      trig2_width_steps <= width_steps(trig2_width_r);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      window_max  <= tic_pkg::WIN_MAX_RST;
      window_min  <= tic_pkg::WIN_MIN_RST;
      window_base <= tic_pkg::WIN_BASE_RST;
    end else if (wr && ofs == tic_pkg::OFS_WINDOW) begin
      window_max  <= wdata_s[13:5];
      window_min  <= wdata_s[22:14];
      window_base <= wdata_s[31:23];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      block_size_r <= tic_pkg::BLOCK_RST;
      data_format  <= tic_pkg::FORMAT_RST;
    end else if (wr && ofs == tic_pkg::OFS_BLOCK) begin
      block_size_r <= wdata_s[7:0];
    end else if (wr && ofs == tic_pkg::OFS_FORMAT) begin
      data_format <= wdata_s[3:0];
    end
  end

  // Bit 24 is a write-only strobe; it never reads back.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_setting     <= tic_pkg::BUS_RST;
      block_decrement <= 1'b0;
    end else begin
      block_decrement <= wr && ofs == tic_pkg::OFS_BUS && wdata_s[tic_pkg::BUS_PULSE_BIT];
      if (wr && ofs == tic_pkg::OFS_BUS) begin
        bus_setting <= wdata_s & tic_pkg::BUS_RW_MASK;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      token_out <= 1'b0;
    end else begin
      token_out <= bus_setting[tic_pkg::TOKEN_IN_BIT] &&
                   bus_setting[tic_pkg::TOKEN_EN_BIT];
    end
  end

  // The launch code is held until the next write of the upper byte.
  logic launch_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_enable    <= tic_pkg::TRIG_SRC_RST;
      force_origin_send <= 1'b0;
      launch_r          <= 1'b0;
    end else begin
      force_origin_send <= wr && ofs == tic_pkg::OFS_TRIG_SRC &&
                           wdata_s[23:16] == tic_pkg::FORCE_CODE;
      if (wr && ofs == tic_pkg::OFS_TRIG_SRC) begin
        trigger_enable <= wdata_s[15:0];
        launch_r       <= wdata_s[31:24] == tic_pkg::LAUNCH_CODE;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fp_out <= 4'h0;
    end else begin
      fp_out <= {launch_r | fp_user_out[3], fp_user_out[2:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_enable <= tic_pkg::SYNC_SRC_RST;
    end else if (wr && ofs == tic_pkg::OFS_SYNC_SRC) begin
      sync_enable <= {8'h00, wdata_s[7:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_level  <= 1'b0;
      last_codes_r <= 12'h000;
    end else if (sync_code_valid) begin
      if (sync_enable[tic_pkg::RESET_OPT_BIT] && sync_code == tic_pkg::SYNC_SET_CODE) begin
        reset_level <= 1'b1;
      end else if (sync_enable[tic_pkg::RESET_OPT_BIT] &&
                   sync_code == tic_pkg::SYNC_CLR_CODE) begin
        reset_level <= 1'b0;
      end
      case (sync_code_src)
        2'h0: last_codes_r[3:0]   <= sync_code[3:0];
        2'h1: last_codes_r[7:4]   <= sync_code[3:0];
        2'h2: last_codes_r[11:8]  <= sync_code[3:0];
        default: last_codes_r     <= last_codes_r;
      endcase
    end
  end

  // History of received sync codes; a code arriving when full is dropped.
  logic [5:0]  hist_mem [HIST_DEPTH];
  logic [PW-1:0] hist_wp_r;
  logic [PW-1:0] hist_rp_r;
  logic [PW:0]   hist_cnt_r;
  logic push;
  logic pop;
  assign hist_empty = (hist_cnt_r == '0);
  assign hist_full  = (hist_cnt_r == (PW+1)'(HIST_DEPTH));
  assign hist_half  = (32'(hist_cnt_r) > 32'(tic_pkg::HIST_HALF));
  assign push = sync_code_valid && !hist_full;
  assign pop  = sync_hist_pop && !hist_empty;

  always_ff @(posedge mclk) begin
    if (push) begin
      hist_mem[hist_wp_r] <= {sync_code_src, sync_code[3:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hist_wp_r  <= '0;
      hist_rp_r  <= '0;
      hist_cnt_r <= '0;
      hist_data  <= 6'h00;
    end else begin
      if (push) begin
        hist_wp_r <= hist_wp_r + 1'b1;
      end
      if (pop) begin
        hist_rp_r <= hist_rp_r + 1'b1;
        hist_data <= hist_mem[hist_rp_r];
      end
      if (push && !pop) begin
        hist_cnt_r <= hist_cnt_r + 1'b1;
      end else if (pop && !push) begin
        hist_cnt_r <= hist_cnt_r - 1'b1;
      end
    end
  end
endmodule

// [tic_assertions.sv]
// Checker for the configuration register bank, attached to its top module.
`timescale 1ns/100ps
module tic_assertions (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        vme_as_n,
  input wire logic        vme_ds_n,
  input wire logic        vme_write_n,
  input wire logic        vme_dtack_n,
  input wire logic        vme_data_oe_n,
  input wire logic        trigger_raw,
  input wire logic        sync_restart_raw,
  input wire logic        trig_out,
  input wire logic        sync_restart_pulse,
  input wire logic [31:0] bus_setting,
  input wire logic        token_out,
  input wire logic [9:0]  trig1_delay_steps,
  input wire logic [9:0]  trig2_delay_steps,
  input wire logic [5:0]  trig1_width_steps,
  input wire logic [5:0]  trig2_width_steps,
  input wire logic        force_origin_send,
  input wire logic [3:0]  fp_user_out,
  input wire logic [3:0]  fp_out,
  input wire logic        reset_level,
  input wire logic [15:0] sync_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Both delay ranges: short steps 1..128, long steps (v+64)*4 up to 764.
  function automatic logic dly_ok(input logic [9:0] s);
    return (s >= 10'h001 && s <= 10'h080) || (s[1:0] == 2'h0 && s >= 10'h100 && s <= 10'h2FC);
  endfunction

  a_trig_gated: assert property (trig_out |-> $past(trigger_raw))
    else $error("Trigger output without raw trigger.");
  a_restart_gated: assert property (sync_restart_pulse |-> $past(sync_restart_raw))
    else $error("Restart output without raw restart.");
  a_token_rule: assert property (
    $stable(bus_setting) |-> token_out == (bus_setting[9] & bus_setting[1]))
    else $error("Token output does not follow its two control bits.");
  a_delay_code: assert property (
    dly_ok(trig1_delay_steps) && dly_ok(trig2_delay_steps))
    else $error("Delay steps outside both encodings.");
  a_width_range: assert property (
    trig1_width_steps inside {[6'h01:6'h20]} &&
    trig2_width_steps inside {[6'h01:6'h20]})
    else $error("Width steps outside one to thirty-two.");
  a_ack_strobe: assert property ($fell(vme_dtack_n) |-> $past(!vme_ds_n, 2) && !vme_as_n)
    else $error("Acknowledge without a held strobe.");
  a_ack_release: assert property ($rose(vme_ds_n) |-> ##[1:6] vme_dtack_n)
    else $error("Acknowledge not released after strobe.");
  a_oe_read: assert property (!vme_data_oe_n |-> vme_write_n)
    else $error("Data driven during a write cycle.");
  a_force_pulse: assert property (force_origin_send |=> !force_origin_send)
    else $error("Force send longer than one cycle.");
  a_fp_follow: assert property ($past(rst_n) |-> fp_out[2:0] == $past(fp_user_out[2:0]))
    else $error("Lower front outputs not under user control.");
  a_reset_opt: assert property ($rose(reset_level) |-> sync_enable[7])
    else $error("Reset level raised with its option off.");

  c_force: cover property (force_origin_send);
  c_reset_high: cover property ($rose(reset_level));
  c_read: cover property ($fell(vme_data_oe_n));
endmodule

bind tic_trigger_interface_config_regs tic_assertions tic_assertions_i (.*);

// [tic_host_model.sv]
// Host bus master model issuing single A24 D32 cycles.
`timescale 1ns/100ps
module tic_host_model (
  input  wire logic        mclk,
  input  wire logic        vme_dtack_n,
  input  wire logic [31:0] vme_data_out,
  output logic      [23:2] vme_addr,
  output logic      [5:0]  vme_am,
  output logic             vme_as_n,
  output logic             vme_ds_n,
  output logic             vme_write_n,
  output logic      [31:0] vme_data_in
);
  initial begin
    vme_addr = '0;
    vme_am = 6'h00;
    vme_as_n = 1'b1;
    vme_ds_n = 1'b1;
    vme_write_n = 1'b1;
    vme_data_in = 32'h0000_0000;
  end
  // Everything is held until acknowledge is sampled low; a missing answer ends after 20 edges.
  task automatic access(input logic wr, input logic [23:2] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
    int n;
    @(posedge mclk);
    vme_addr <= adr;
    vme_am <= tic_pkg::AM_A24_0;
    vme_write_n <= !wr;
    vme_data_in <= wr ? wd : ~vme_data_in;
    vme_as_n <= 1'b0;
    @(posedge mclk);
    vme_ds_n <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (vme_dtack_n !== 1'b0 && n < 20);
    ok = (vme_dtack_n === 1'b0);
    rd = vme_data_out;
    vme_ds_n <= 1'b1;
    vme_as_n <= 1'b1;
    // Released data lines must not keep showing the last word.
    vme_data_in <= ~vme_data_in;
    n = 0;
    while (vme_dtack_n === 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
  endtask
endmodule

// [tic_trigger_interface_config_regs_tb.sv]
// Self-checking bench for the configuration register bank.
`timescale 1ns/100ps
module tic_trigger_interface_config_regs_tb;
  logic        mclk, rst_n, vme_as_n, vme_ds_n, vme_write_n, vme_data_oe_n, vme_dtack_n;
  logic        ga_parity_n, vme64x_crate, sync_code_valid, sync_hist_pop, trigger_raw;
  logic        sync_restart_raw, trig_out, sync_restart_pulse, irq_enable, block_decrement;
  logic        token_out, force_origin_send, reset_level, ok;
  logic [1:0]  running_mode, sync_code_src;
  logic [2:0]  irq_level;
  logic [3:0]  fp_user_out, fp_out, data_format;
  logic [4:0]  ga_n, slot_switches, slot;
  logic [5:0]  vme_am, trig1_width_steps, trig2_width_steps, hist_data;
  logic [7:0]  sync_code, crate_id, optical_port_enable, irq_vector;
  logic [7:0]  link_synced = 8'hA5;
  logic [7:0]  remote_trig_on = 8'h3C;
  logic [7:0]  block_level_used = 8'h11;
  logic [7:0]  block_level_master = 8'h22;
  logic [7:0]  buffer_level_used = 8'h33;
  logic [7:0]  buffer_level_master = 8'h44;
  logic [7:0]  sync_monitor = 8'h5A;
  logic [8:0]  window_max, window_min, window_base;
  logic [9:0]  trig1_delay_steps, trig2_delay_steps;
  logic [15:0] trigger_monitor = 16'hBEEF;
  logic [15:0] trigger_enable, sync_enable;
  logic [23:2] vme_addr;
  logic [31:0] vme_data_in, vme_data_out, bus_setting, rd;
  int          miscompares, checked, fcount;
  logic [31:0] rst_v [10] = '{32'h5A01_0500, 32'h3CA5_01FF, 32'h0000_05C8, 32'h0700_0700,
    32'h8000_3FE0, 32'h2211_0001, 32'h4433_0003, 32'h0000_0011, 32'hBEEF_0000, 32'h5A10_0002};
  logic [31:0] rw_m [10] = '{32'h0000_00FF, 32'h0000_01FF, 32'h0001_07FF, 32'h1FFF_1FFF,
    32'hFFFF_FFE0, 32'h0000_00FF, 32'h0000_000F, 32'hFAF3_8F9F, 32'h0000_FFFF, 32'h0000_00FF};

  tic_trigger_interface_config_regs #(.HIST_DEPTH(16)) tic_trigger_interface_config_regs_i (.*);
  tic_host_model tic_host_model_i (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Decrement pulses count sixteen each.
  always @(posedge mclk) fcount += (force_origin_send === 1'b1) + 16 * (block_decrement === 1'b1);

  task automatic report_and_stop();
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [23:2] adr(input logic [5:0] ofs);
    return {slot, 13'h0000, ofs[5:2]};
  endfunction
  task automatic wr(input logic [5:0] ofs, input logic [31:0] d);
    tic_host_model_i.access(1'b1, adr(ofs), d, rd, ok);
    check("write answer", {31'h0, ok}, 32'h1);
  endtask
  task automatic rchk(input logic [5:0] ofs, input logic [31:0] exp);
    tic_host_model_i.access(1'b0, adr(ofs), 32'h0, rd, ok);
    check("read answer", {31'h0, ok}, 32'h1);
    check("read data", rd, exp);
  endtask
  task automatic code(input logic [1:0] src, input logic [7:0] c);
    @(posedge mclk);
    sync_code_valid <= 1'b1;
    sync_code_src <= src;
    sync_code <= c;
    @(posedge mclk);
    sync_code_valid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    #300000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    slot = 5'h05;
    ga_n = 5'h1F;
    ga_parity_n = 1'b1;
    vme64x_crate = 1'b0;
    slot_switches = 5'h05;
    running_mode = 2'h0;
    sync_code_valid = 1'b0;
    sync_code = 8'h00;
    sync_code_src = 2'h0;
    sync_hist_pop = 1'b0;
    trigger_raw = 1'b1;
    sync_restart_raw = 1'b1;
    fp_user_out = 4'h2;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rchk(6'(4 * i), rst_v[i]);
    check("width steps", {26'h0, trig1_width_steps}, 32'h8);
    for (int i = 0; i < 10; i++) begin
      wr(6'(4 * i), 32'hFFFF_FFFF);
      rchk(6'(4 * i), rst_v[i] | rw_m[i]);
    end
    check("trigger out", {31'h0, trig_out}, 32'h1);
    check("token out", {31'h0, token_out}, 32'h1);
    check("delay one", {22'h0, trig1_delay_steps}, 32'h2FC);
    check("delay two", {22'h0, trig2_delay_steps}, 32'h2FC);
    check("width two", {26'h0, trig2_width_steps}, 32'h20);
    for (int i = 0; i < 10; i++) begin
      wr(6'(4 * i), 32'h0000_0000);
      rchk(6'(4 * i), rst_v[i] & ~rw_m[i]);
    end
    check("trigger gated", {30'h0, trig_out, sync_restart_pulse}, 32'h0);
    check("token low", {31'h0, token_out}, 32'h0);
    check("width one", {26'h0, trig1_width_steps}, 32'h1);
    check("port enables", {24'h0, optical_port_enable}, 32'h0);
    check("pulse count", 32'(fcount), 32'h10);
    wr(6'h0C, 32'h007F_0080);
    check("long delay", {22'h0, trig1_delay_steps}, 32'h100);
    check("short delay", {22'h0, trig2_delay_steps}, 32'h80);
    fcount = 0;
    wr(6'h20, 32'h90FC_0001);
    check("front out launch", {28'h0, fp_out}, 32'hA);
    wr(6'h20, 32'h0000_0001);
    check("force count", 32'(fcount), 32'h1);
    check("front out user", {28'h0, fp_out}, 32'h2);
    rchk(6'h20, 32'hBEEF_0001);
    wr(6'h24, 32'h0000_0080);
    code(2'h0, 8'h99);
    check("reset set", {31'h0, reset_level}, 32'h1);
    code(2'h2, 8'hCC);
    check("reset clear", {31'h0, reset_level}, 32'h0);
    rchk(6'h24, 32'h5A0C_0980);
    for (int i = 0; i < 14; i++) code(2'h1, 8'h01);
    rchk(6'h24, 32'h5A4C_1980);
    repeat (16) begin
      @(posedge mclk);
      sync_hist_pop <= 1'b1;
      @(posedge mclk);
      sync_hist_pop <= 1'b0;
    end
    rchk(6'h24, 32'h5A1C_1980);
    check("history out", {26'h0, hist_data}, 32'h11);
    wr(6'h24, 32'h0000_0000);
    code(2'h0, 8'h99);
    check("reset option off", {31'h0, reset_level}, 32'h0);
    running_mode <= 2'h2;
    wr(6'h00, 32'h0000_0077);
    rchk(6'h00, 32'h5A01_8500);
    running_mode <= 2'h0;
    vme64x_crate <= 1'b1;
    ga_n <= 5'h19;
    ga_parity_n <= 1'b0;
    repeat (4) @(posedge mclk);
    tic_host_model_i.access(1'b0, adr(6'h00), 32'h0, rd, ok);
    check("old slot answer", {31'h0, ok}, 32'h0);
    slot = 5'h06;
    rchk(6'h00, 32'h5A01_2600);
    tic_host_model_i.access(1'b0, adr(6'h28), 32'h0, rd, ok);
    check("unmapped answer", {31'h0, ok}, 32'h0);
    report_and_stop();
  end
endmodule
